// ===== design/tsx_pkg.sv
//==============================================================
// Behaviour
// - A table write stores the table latch byte into the holding register picked by pointer bits 2..0.
// - The table pointer is a 21-bit byte address over a 2-MByte program space.
// - Pointer bit 0 picks the low byte of a program word when 0 and the high byte when 1.
// - The table write mode field in opcode bits 1..0 means 0 keep, 1 post-inc, 2 post-dec, 3 pre-inc.
// - Pre-increment bumps the pointer first and writes to the register the new pointer selects.
// - Post-decrement writes to the register the current pointer selects, then drops the pointer.
// - A zero-test that finds zero flushes the next instruction as a no-op, taking two cycles.
// - If the flushed instruction has two words the skip costs three cycles in total.
// - The zero-test opcode is its upper seven bits, then the access bit and an 8-bit file address.
// - Access bit 0 selects the access bank and ignores the bank select register; 1 uses it.
// - The literal XOR combines the working register with an 8-bit immediate into it in one cycle.
// - The literal XOR opcode is its upper eight bits, with the literal in the lower eight.
// - The file XOR writes the working register when the destination bit is 0, else the file.
// - The file XOR opcode is six upper bits, destination, access and address, in one cycle.
// - Only the XORs touch flags, and only negative and zero; the others change no flag.
//==============================================================
`default_nettype none
package tsx_pkg;
  // Timing: four clock phases per instruction cycle
  localparam logic [1:0] Q_LAST = 2'h3;
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;
  // Widths
  localparam int unsigned TPTR_W = 21;
  localparam int unsigned PC_W = 21;
  localparam int unsigned FA_W = 12;
  localparam int unsigned BANK_W = 4;
  // Register offsets
  localparam logic [7:0] OFF_INSTR = 8'h00;
  localparam logic [7:0] OFF_STATE = 8'h04;
  localparam logic [7:0] OFF_FLAGS = 8'h08;
  localparam logic [7:0] OFF_WREG = 8'h0C;
  localparam logic [7:0] OFF_TPTR = 8'h10;
  localparam logic [7:0] OFF_TLAT = 8'h14;
  localparam logic [7:0] OFF_BANK = 8'h18;
  localparam logic [7:0] OFF_PC = 8'h1C;
  localparam logic [7:0] OFF_FADDR = 8'h20;
  localparam logic [7:0] OFF_FDATA = 8'h24;
  localparam logic [7:0] OFF_CYC = 8'h28;
  localparam logic [2:0] HOLD_WINDOW = 3'h2;
  // Field positions
  localparam int unsigned INSTR_TWO_WORD_BIT = 16;
  localparam int unsigned STATE_BUSY_BIT = 0;
  localparam int unsigned STATE_SKIP_BIT = 1;
  localparam int unsigned FLAG_Z_BIT = 2;
  localparam int unsigned FLAG_N_BIT = 4;
  localparam int unsigned OP_A_BIT = 8;
  localparam int unsigned OP_D_BIT = 9;
  // Opcode patterns
  localparam logic [13:0] OPC_TABLE_WRITE = 14'h0003;
  localparam logic [6:0] OPC_TEST_ZERO = 7'h33;
  localparam logic [7:0] OPC_XOR_LIT = 8'h0A;
  localparam logic [5:0] OPC_XOR_FILE = 6'h06;
  // Access bank halves
  localparam logic [3:0] ACC_LOW_BANK = 4'h0;
  localparam logic [3:0] ACC_HIGH_BANK = 4'hF;
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] RST_HOLD = 8'hFF;
  localparam logic [20:0] RST_TPTR = 21'h000000;
  localparam logic [20:0] RST_PC = 21'h000000;
  localparam logic [3:0] RST_BANK = 4'h0;
  localparam logic [11:0] RST_FADDR = 12'h000;
  localparam logic [15:0] RST_CYC = 16'h0000;

  typedef enum logic [1:0] {TW_KEEP, TW_POSTINC, TW_POSTDEC, TW_PREINC} tsx_twmode_e;
  typedef enum logic {ENG_IDLE, ENG_RUN} tsx_eng_e;
endpackage
`default_nettype wire

// ===== design/tsx_file_mem.sv
`timescale 1ns/1ps
`default_nettype none
module tsx_file_mem
  import tsx_pkg::*;
#(
  parameter int unsigned DEPTH = 256
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Write port
  input wire logic wrEn,
  input wire logic [FA_W-1:0] wrAddr,
  input wire logic [7:0] wrData,
  // Read ports
  input wire logic [FA_W-1:0] rdAddrA,
  output logic [7:0] rdDataA,
  input wire logic [FA_W-1:0] rdAddrB,
  output logic [7:0] rdDataB
);
  localparam int unsigned IW = $clog2(DEPTH);
  logic [7:0] mem [DEPTH];

  //==============================================================
  // Storage; banks beyond the depth alias onto it
  genvar i;
  generate
    for (i = 0; i < DEPTH; i++) begin : gEntry
      always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
          mem[i] <= RST_BYTE;
        end else if (wrEn && wrAddr[IW-1:0] == IW'(i)) begin
          mem[i] <= wrData;
        end
      end
    end
  endgenerate

  assign rdDataA = mem[rdAddrA[IW-1:0]];
  assign rdDataB = mem[rdAddrB[IW-1:0]];
endmodule // tsx_file_mem
`default_nettype wire

// ===== design/tsx_core.sv
`timescale 1ns/1ps
`default_nettype none
module tsx_core
  import tsx_pkg::*;
#(
  parameter int unsigned FILE_DEPTH = 256
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata
);
  //==============================================================
  // Declarations
  tsx_eng_e eng;
  tsx_twmode_e twMode;
  logic [15:0] op;
  logic twoWord, flushing, skipPending;
  logic [1:0] qPhase, cycLeft;
  logic [7:0] wReg, flags, tableLatch, fileRd, busFileRd, xorRes;
  logic [TPTR_W-1:0] table_pointer, ptrInc, ptrDec;
  logic [PC_W-1:0] pc;
  logic [BANK_W-1:0] bankSel;
  logic [FA_W-1:0] fileAddr, bankAddr, memWa;
  logic [15:0] cycCnt;
  logic [7:0] hold [8];
  logic [2:0] holdIdx;
  logic isTblWr, isTst, isXorl, isXorf, commit, exec, busy;
  logic dpValid, dpWrite, rdReady, busWr, instrStart, memWe;
  logic [7:0] dpAddr, memWd;
  logic [31:0] rdVal;

  //==============================================================
  // Decode
  assign isTblWr = op[15:2] == OPC_TABLE_WRITE;
  assign isTst = op[15:9] == OPC_TEST_ZERO;
  assign isXorl = op[15:8] == OPC_XOR_LIT;
  assign isXorf = op[15:10] == OPC_XOR_FILE;
  assign twMode = tsx_twmode_e'(op[1:0]);
  assign busy = eng == ENG_RUN;
  assign commit = busy && qPhase == Q_LAST && cycLeft == CYC_ONE;
  // Flushed slots never execute, only step the program and cycle counters
  assign exec = commit && !flushing;

  always_comb begin
    if (op[OP_A_BIT]) begin
      bankAddr = {bankSel, op[7:0]};
    end else if (op[7]) begin
      bankAddr = {ACC_HIGH_BANK, op[7:0]};
    end else begin
      bankAddr = {ACC_LOW_BANK, op[7:0]};
    end
  end

  assign xorRes = wReg ^ (isXorl ? op[7:0] : fileRd);
  assign ptrInc = table_pointer + TPTR_W'(1);
  assign ptrDec = table_pointer - TPTR_W'(1);
  // Bit 0 of the index is the byte within the program word
  assign holdIdx = (twMode == TW_PREINC) ? ptrInc[2:0] : table_pointer[2:0];

  //==============================================================
  // AHB-Lite slave
  assign hresp = 1'b0;
  // Accesses stall while an instruction runs, so bus and engine never collide
  assign hreadyout = !dpValid || (dpWrite ? !busy : rdReady);
  assign busWr = dpValid && dpWrite && !busy;
  assign instrStart = busWr && dpAddr == OFF_INSTR;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      dpValid <= 1'b0;
      dpWrite <= 1'b0;
      dpAddr <= RST_BYTE;
    end else if (hready) begin
      dpValid <= hsel && htrans[1];
      dpWrite <= hwrite;
      dpAddr <= haddr[7:0];
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rdReady <= 1'b0;
    end else if (hreadyout) begin
      rdReady <= 1'b0;
    end else if (dpValid && !dpWrite && !busy) begin
      rdReady <= 1'b1;
    end
  end

  always_comb begin
    rdVal = 32'h0000_0000;
    if (dpAddr[7:5] == HOLD_WINDOW) begin
      rdVal[7:0] = hold[dpAddr[4:2]];
    end else begin
      case (dpAddr)
        OFF_INSTR: rdVal[16:0] = {twoWord, op};
        OFF_STATE: rdVal[1:0] = {skipPending, busy};
        OFF_FLAGS: rdVal[7:0] = flags;
        OFF_WREG: rdVal[7:0] = wReg;
        OFF_TPTR: rdVal[TPTR_W-1:0] = table_pointer;
        OFF_TLAT: rdVal[7:0] = tableLatch;
        OFF_BANK: rdVal[BANK_W-1:0] = bankSel;
        OFF_PC: rdVal[PC_W-1:0] = pc;
        OFF_FADDR: rdVal[FA_W-1:0] = fileAddr;
        OFF_FDATA: rdVal[7:0] = busFileRd;
        OFF_CYC: rdVal[15:0] = cycCnt;
        default: rdVal = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      hrdata <= 32'h0000_0000;
    end else if (dpValid && !dpWrite && !busy && !rdReady) begin
      hrdata <= rdVal;
    end
  end

  //==============================================================
  // Engine: one instruction cycle is four clock phases
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      eng <= ENG_IDLE;
      qPhase <= 2'h0;
      cycLeft <= 2'h0;
      op <= 16'h0000;
      twoWord <= 1'b0;
      flushing <= 1'b0;
    end else begin
      case (eng)
        ENG_IDLE: begin
          if (instrStart) begin
            eng <= ENG_RUN;
            qPhase <= 2'h0;
            op <= hwdata[15:0];
            twoWord <= hwdata[INSTR_TWO_WORD_BIT];
            flushing <= skipPending;
            if (skipPending) begin
              cycLeft <= hwdata[INSTR_TWO_WORD_BIT] ? CYC_TWO : CYC_ONE;
            end else begin
              cycLeft <= (hwdata[15:2] == OPC_TABLE_WRITE) ? CYC_TWO : CYC_ONE;
            end
          end
        end
        ENG_RUN: begin
          qPhase <= qPhase + 2'h1;
          if (qPhase == Q_LAST) begin
            cycLeft <= cycLeft - 2'h1;
            if (cycLeft == CYC_ONE) begin
              eng <= ENG_IDLE;
            end
          end
        end
        default: eng <= ENG_IDLE;
      endcase
    end
  end

  // Set wins if a zero result and the next instruction ever coincide
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      skipPending <= 1'b0;
    end else if (exec && isTst && fileRd == RST_BYTE) begin
      skipPending <= 1'b1;
    end else if (instrStart) begin
      skipPending <= 1'b0;
    end
  end

  //==============================================================
  // Architectural state
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wReg <= RST_BYTE;
    end else if (exec && (isXorl || (isXorf && !op[OP_D_BIT]))) begin
      wReg <= xorRes;
    end else if (busWr && dpAddr == OFF_WREG) begin
      wReg <= hwdata[7:0];
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      flags <= RST_BYTE;
    end else if (exec && (isXorl || isXorf)) begin
      flags[FLAG_N_BIT] <= xorRes[7];
      flags[FLAG_Z_BIT] <= xorRes == RST_BYTE;
    end else if (busWr && dpAddr == OFF_FLAGS) begin
      flags <= hwdata[7:0];
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      table_pointer <= RST_TPTR;
    end else if (exec && isTblWr) begin
      case (twMode)
        TW_POSTINC, TW_PREINC: table_pointer <= ptrInc;
        TW_POSTDEC: table_pointer <= ptrDec;
        default: table_pointer <= table_pointer;
      endcase
    end else if (busWr && dpAddr == OFF_TPTR) begin
      table_pointer <= hwdata[TPTR_W-1:0];
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      tableLatch <= RST_BYTE;
      bankSel <= RST_BANK;
      fileAddr <= RST_FADDR;
    end else if (busWr) begin
      if (dpAddr == OFF_TLAT) begin
        tableLatch <= hwdata[7:0];
      end
      if (dpAddr == OFF_BANK) begin
        bankSel <= hwdata[BANK_W-1:0];
      end
      if (dpAddr == OFF_FADDR) begin
        fileAddr <= hwdata[FA_W-1:0];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pc <= RST_PC;
    end else if (commit) begin
      pc <= pc + (twoWord ? PC_W'(2) : PC_W'(1));
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cycCnt <= RST_CYC;
    end else if (busy && qPhase == Q_LAST) begin
      cycCnt <= cycCnt + 16'h0001;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : gHold
      always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
          hold[g] <= RST_HOLD;
        end else if (exec && isTblWr && holdIdx == 3'(g)) begin
          hold[g] <= tableLatch;
        end
      end
    end
  endgenerate

  //==============================================================
  // File registers
  assign memWe = (exec && isXorf && op[OP_D_BIT]) || (busWr && dpAddr == OFF_FDATA);
  assign memWa = busWr ? fileAddr : bankAddr;
  assign memWd = busWr ? hwdata[7:0] : xorRes;

  tsx_file_mem #(.DEPTH(FILE_DEPTH)) uMem (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .wrEn(memWe),
    .wrAddr(memWa),
    .wrData(memWd),
    .rdAddrA(bankAddr),
    .rdDataA(fileRd),
    .rdAddrB(fileAddr),
    .rdDataB(busFileRd)
  );

  //==============================================================
  // Assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  AST_HOLD_CURRENT: assert property (
    exec && isTblWr && twMode != TW_PREINC |=> hold[$past(table_pointer[2:0])] == $past(tableLatch))
    else $error("holding register at pointer not written");
  AST_PRE_INC: assert property (
    exec && isTblWr && twMode == TW_PREINC
    |=> table_pointer == $past(ptrInc) && hold[$past(ptrInc[2:0])] == $past(tableLatch))
    else $error("pre-increment order wrong");
  AST_POST_DEC: assert property (
    exec && isTblWr && twMode == TW_POSTDEC |=> table_pointer == $past(table_pointer) - TPTR_W'(1))
    else $error("post-decrement wrong");
  AST_KEEP: assert property (
    exec && isTblWr && twMode == TW_KEEP |=> $stable(table_pointer))
    else $error("pointer moved in keep mode");
  AST_SKIP_SET: assert property (
    exec && isTst && fileRd == RST_BYTE |=> skipPending)
    else $error("zero test did not arm skip");
  AST_TWO_WORD_FLUSH: assert property (
    instrStart && skipPending && hwdata[INSTR_TWO_WORD_BIT] |=> busy [*8] ##1 !busy)
    else $error("two-word flush not two cycles");
  AST_FLUSH_QUIET: assert property (
    commit && flushing |=> $stable(wReg) && $stable(flags) && $stable(table_pointer))
    else $error("flushed slot changed state");
  AST_XOR_LITERAL: assert property (
    exec && isXorl |=> wReg == ($past(wReg) ^ $past(op[7:0])))
    else $error("literal xor result wrong");
  AST_XOR_Z: assert property (
    exec && isXorf |=> flags[FLAG_Z_BIT] == ($past(xorRes) == RST_BYTE))
    else $error("zero flag wrong");
  AST_NO_FLAGS: assert property (
    exec && (isTblWr || isTst) |=> $stable(flags))
    else $error("flags changed");
  AST_XOR_FILE_DEST: assert property (
    exec && isXorf && op[OP_D_BIT] |=> $stable(wReg))
    else $error("file-destination xor touched working register");

  COV_SKIP_TWO: cover property (instrStart && skipPending && hwdata[INSTR_TWO_WORD_BIT]);
  COV_PRE_INC: cover property (exec && isTblWr && twMode == TW_PREINC);
  COV_XOR_FILE_WB: cover property (exec && isXorf && op[OP_D_BIT]);
endmodule // tsx_core
`default_nettype wire

// ===== verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
//==============================================================
// Compare helper
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin n_fail++; \
  $display("wrong value %s expected %h seen %h", nm, exp, got); end end
module tb_top;
  import tsx_pkg::*;
  logic sys_clk, nrst, hsel, hwrite;
  logic [31:0] haddr, hwdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  wire logic hreadyout, hresp;
  wire logic [31:0] hrdata;
  int n_fail = 0;
  int check_count = 0;
  int cycles = 0;
  localparam logic [20:0] TW_PTR[4] = '{21'h00A357, 21'h00A356, 21'h000000, 21'h01389A};
  localparam logic [20:0] TW_END[4] = '{21'h00A357, 21'h00A357, 21'h1FFFFF, 21'h01389B};
  localparam logic [7:0] TW_LAT[4] = '{8'h11, 8'h55, 8'h22, 8'h34};
  localparam int TW_IDX[4] = '{7, 6, 0, 3};

  // Deep file so bank bits are not aliased away
  tsx_core #(.FILE_DEPTH(4096)) i_dut (
    .sys_clk(sys_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata)
  );

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  //==============================================================
  // Bus master
  // Ready is looked at on the falling edge, half a cycle before the rising edge, so no race with the edge itself
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h000000, a};
    do @(negedge sys_clk); while (hreadyout !== 1'b1);
    @(posedge sys_clk);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(negedge sys_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    `CHK("response", 1'b0, hresp)
    @(posedge sys_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e, input string nm);
    logic [31:0] x;
    ahb(1'b0, a, 32'h00000000, x);
    `CHK(nm, e, x)
  endtask

  task automatic exec(input logic [16:0] op);
    wr(OFF_INSTR, {15'h0000, op});
  endtask

  //==============================================================
  // Scenarios
  task automatic test_reset;
    for (int i = 0; i < 8; i++) rc(8'(8'h40 + 4 * i), 32'h000000FF, "hold reset");
    rc(OFF_TPTR, 32'h00000000, "pointer reset");
    $display("test reset done");
  endtask

  task automatic test_table_write_op;
    wr(OFF_FLAGS, 32'h00000014);
    for (int m = 0; m < 4; m++) begin
      wr(OFF_TPTR, {11'h000, TW_PTR[m]});
      wr(OFF_TLAT, {24'h000000, TW_LAT[m]});
      exec({1'b0, OPC_TABLE_WRITE, 2'(m)});
      rc(8'(8'h40 + 4 * TW_IDX[m]), {24'h000000, TW_LAT[m]}, "hold byte");
      rc(OFF_TPTR, {11'h000, TW_END[m]}, "table pointer");
    end
    rc(8'h48, 32'h000000FF, "untouched hold");
    rc(OFF_FLAGS, 32'h00000014, "flags after table write");
    $display("test table write done");
  endtask

  task automatic test_xor;
    wr(OFF_FLAGS, 32'h000000FF);
    wr(OFF_WREG, 32'h000000B5);
    exec({1'b0, OPC_XOR_LIT, 8'hAF});
    rc(OFF_WREG, 32'h0000001A, "literal result");
    rc(OFF_FLAGS, 32'h000000EB, "flags clear");
    exec({1'b0, OPC_XOR_LIT, 8'h1A});
    rc(OFF_FLAGS, 32'h000000EF, "zero flag");
    exec({1'b0, OPC_XOR_LIT, 8'h80});
    rc(OFF_FLAGS, 32'h000000FB, "negative flag");
    wr(OFF_BANK, 32'h00000002);
    wr(OFF_FADDR, 32'h000002AA);
    wr(OFF_FDATA, 32'h000000AF);
    wr(OFF_FADDR, 32'h00000010);
    wr(OFF_FDATA, 32'h000000B5);
    wr(OFF_WREG, 32'h000000B5);
    exec({1'b0, OPC_XOR_FILE, 2'b11, 8'hAA});
    rc(OFF_WREG, 32'h000000B5, "w kept");
    wr(OFF_FADDR, 32'h000002AA);
    rc(OFF_FDATA, 32'h0000001A, "file result");
    rc(OFF_FLAGS, 32'h000000EB, "flags file xor");
    exec({1'b0, OPC_XOR_FILE, 2'b00, 8'h10});
    rc(OFF_WREG, 32'h00000000, "w result access bank");
    rc(OFF_FLAGS, 32'h000000EF, "flags zero file");
    $display("test xor done");
  endtask

  task automatic test_skip;
    logic [31:0] pc0, cy0;
    wr(OFF_BANK, 32'h00000001);
    wr(OFF_FADDR, 32'h00000155);
    wr(OFF_FDATA, 32'h00000000);
    wr(OFF_FADDR, 32'h00000055);
    wr(OFF_FDATA, 32'h00000001);
    wr(OFF_FADDR, 32'h00000F80);
    wr(OFF_FDATA, 32'h00000000);
    wr(OFF_FADDR, 32'h00000180);
    wr(OFF_FDATA, 32'h00000007);
    wr(OFF_WREG, 32'h0000003C);
    wr(OFF_FLAGS, 32'h00000000);
    ahb(1'b0, OFF_PC, 32'h00000000, pc0);
    ahb(1'b0, OFF_CYC, 32'h00000000, cy0);
    exec({1'b0, OPC_TEST_ZERO, 1'b1, 8'h55});
    rc(OFF_STATE, 32'h00000002, "skip armed");
    exec({1'b0, OPC_XOR_LIT, 8'hFF});
    rc(OFF_WREG, 32'h0000003C, "flushed w");
    rc(OFF_FLAGS, 32'h00000000, "flushed flags");
    rc(OFF_PC, pc0 + 2, "pc after skip");
    rc(OFF_CYC, cy0 + 2, "cycles after skip");
    exec({1'b0, OPC_TEST_ZERO, 1'b0, 8'h55});
    exec({1'b0, OPC_XOR_LIT, 8'h0F});
    rc(OFF_WREG, 32'h00000033, "no skip w");
    rc(OFF_CYC, cy0 + 4, "cycles no skip");
    exec({1'b0, OPC_TEST_ZERO, 1'b0, 8'h80});
    exec({1'b1, OPC_XOR_LIT, 8'h01});
    rc(OFF_WREG, 32'h00000033, "two word flushed");
    rc(OFF_PC, pc0 + 7, "pc two word");
    rc(OFF_CYC, cy0 + 7, "cycles two word");
    $display("test skip done");
  endtask

  task automatic test_unmapped;
    wr(8'h30, 32'h000000A5);
    rc(8'h30, 32'h00000000, "unmapped read");
    $display("test unmapped done");
  endtask

  //==============================================================
  // Verdict
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Whole run needs a few hundred cycles; this ceiling only cuts a hang
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail++;
      $display("wrong value run length expected %h seen %h", 20000, cycles);
      summarize();
    end
  end

  initial begin
    nrst = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    haddr = 32'h00000000;
    hwdata = 32'h00000000;
    htrans = 2'h0;
    hsize = 3'h2;
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    test_reset();
    test_table_write_op();
    test_xor();
    test_skip();
    test_unmapped();
    summarize();
  end
endmodule // tb_top
`default_nettype wire
